// ==== audio_clock_source.sv ====
// Purpose: behavioural serial audio clock source
// Assumes: frame length given in device clock cycles, clock counts given per frame
// Notes: clocks run free, as a real source does between frames
module audio_clock_source (
    // system
    input wire logic clk,
    input wire logic rst,
    // frame length in clk cycles and clocks per frame
    input wire logic [15:0] period,
    input wire logic [11:0] mclk_ratio,
    input wire logic [8:0] bclk_ratio,
    // audio clocks
    output logic mclk,
    output logic bclk,
    output logic lrclk
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // phase spread evenly over the frame: exactly r rising edges per frame
    function automatic logic phase(input int r);
        return (cnt * 2 * r / int'(period)) % 2 == 1;
    endfunction
    always @(negedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 0;
            mclk <= 1'b0;
            bclk <= 1'b0;
            lrclk <= 1'b0;
        end
        else
        begin
            cnt <= (cnt + 1 >= int'(period)) ? 0 : cnt + 1;
            lrclk <= cnt < int'(period) / 2;
            mclk <= phase(int'(mclk_ratio));
            bclk <= phase(int'(bclk_ratio));
        end
    end
endmodule

// ==== clk_ratio_meter.v ====
// Purpose: counts device clocks, master clocks and bit clocks per frame
// Assumes: clock inputs already synchronous to clk, frame edge = lrclk rise
// Notes: a missing frame clock ends a measurement by timeout
module clk_ratio_meter #(
    parameter PERIOD_W = 16,
    parameter MCLK_W = 12,
    parameter BCLK_W = 9
) (
    // system
    input wire clk,
    input wire rst,
    // sampled audio clocks
    input wire mclk_in,
    input wire bclk_in,
    input wire lrclk_in,
    // measurement result
    output reg [PERIOD_W-1:0] period_r,
    output reg [MCLK_W-1:0] mclk_cnt_r,
    output reg [BCLK_W-1:0] bclk_cnt_r,
    output reg done_r,
    output reg timeout_r
);

    reg mclk_d_r, bclk_d_r, lrclk_d_r, armed_r;
    reg [PERIOD_W-1:0] per_acc_r;
    reg [MCLK_W-1:0] mclk_acc_r;
    reg [BCLK_W-1:0] bclk_acc_r;

    wire frame_edge = lrclk_in & ~lrclk_d_r;
    wire mclk_edge = mclk_in & ~mclk_d_r;
    wire bclk_edge = bclk_in & ~bclk_d_r;
    wire per_full = &per_acc_r;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mclk_d_r <= 1'b0;
            bclk_d_r <= 1'b0;
            lrclk_d_r <= 1'b0;
            armed_r <= 1'b0;
            per_acc_r <= {PERIOD_W{1'b0}};
            mclk_acc_r <= {MCLK_W{1'b0}};
            bclk_acc_r <= {BCLK_W{1'b0}};
            period_r <= {PERIOD_W{1'b0}};
            mclk_cnt_r <= {MCLK_W{1'b0}};
            bclk_cnt_r <= {BCLK_W{1'b0}};
            done_r <= 1'b0;
            timeout_r <= 1'b0;
        end
        else
        begin
            mclk_d_r <= mclk_in;
            bclk_d_r <= bclk_in;
            lrclk_d_r <= lrclk_in;
            done_r <= 1'b0;
            timeout_r <= 1'b0;
            if (frame_edge | per_full)
            begin
                // the first frame edge only starts a window: no result yet
                if (armed_r | per_full)
                begin
                    period_r <= per_acc_r;
                    mclk_cnt_r <= mclk_acc_r;
                    bclk_cnt_r <= bclk_acc_r; // R13
                    done_r <= 1'b1;
                    timeout_r <= per_full;
                end
                armed_r <= frame_edge;
                per_acc_r <= {{(PERIOD_W-1){1'b0}}, 1'b1};
                mclk_acc_r <= {{(MCLK_W-1){1'b0}}, mclk_edge};
                bclk_acc_r <= {{(BCLK_W-1){1'b0}}, bclk_edge};
            end
            else
            begin
                per_acc_r <= per_acc_r + 1'b1;
                // counters stick at full scale rather than wrap
                if (mclk_edge && !(&mclk_acc_r))
                    mclk_acc_r <= mclk_acc_r + 1'b1;
                if (bclk_edge && !(&bclk_acc_r))
                    bclk_acc_r <= bclk_acc_r + 1'b1;
            end
        end
    end

endmodule

// ==== clock_detect_defines.vh ====
// Purpose: shared constants for the clock detector and pin polarity bank
// Assumes: 250 MHz device clock, 8-bit register port
// Notes: counts are derived from the clock rate, not typed in by hand
`ifndef CLOCK_DETECT_DEFINES_VH
`define CLOCK_DETECT_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PIN_OUTPUT_POLARITY 8'h57
`define OFS_DIE_IDENTIFIER 8'h58
`define OFS_DETECTED_RATE_RATIO 8'h5B
`define OFS_BITCLK_RATIO_HIGH 8'h5C
`define OFS_BITCLK_RATIO_LOW 8'h5D

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define POL_AUX_B_INVERT_BIT 5
`define POL_MUTE_INVERT_BIT 4
`define POL_AUX_A_INVERT_BIT 3
`define POL_RESET 8'h00
`define RATE_FIELD_MSB 6
`define RATE_FIELD_LSB 4
`define RATIO_FIELD_MSB 3
`define RATIO_FIELD_LSB 0
`define BITCLK_MSB_BIT 0
`define DETECT_RESET 8'h00

// ----------------------------------------------------------------
// rate class codes
// ----------------------------------------------------------------
`define RATE_ERR 3'h0
`define RATE_8K 3'h1
`define RATE_16K 3'h2
`define RATE_32_48K 3'h3
`define RATE_88_96K 3'h4
`define RATE_176_192K 3'h5
`define RATE_384K 3'h6
`define RATIO_ERR 4'h0

// ----------------------------------------------------------------
// timing: frame period windows in device clock cycles
// ----------------------------------------------------------------
`define CLK_HZ 250000000
`define MCLK_MAX_HZ 50000000
// mclk at or above the limit when mclk_cnt * CLK_HZ/MCLK_MAX_HZ >= period
`define MCLK_LIMIT_FACTOR (`CLK_HZ / `MCLK_MAX_HZ)
`define WIN_384K_MIN (`CLK_HZ / 400000)
`define WIN_384K_MAX (`CLK_HZ / 360000)
`define WIN_192K_MIN (`CLK_HZ / 200000)
`define WIN_192K_MAX (`CLK_HZ / 169000)
`define WIN_96K_MIN (`CLK_HZ / 100000)
`define WIN_96K_MAX (`CLK_HZ / 84500)
`define WIN_48K_MIN (`CLK_HZ / 50000)
`define WIN_48K_MAX (`CLK_HZ / 30500)
`define WIN_16K_MIN (`CLK_HZ / 16700)
`define WIN_16K_MAX (`CLK_HZ / 15300)
`define WIN_8K_MIN (`CLK_HZ / 8350)
`define WIN_8K_MAX (`CLK_HZ / 7650)

`endif

// ==== clock_detect_gpio_polarity.v ====
// Purpose: pin polarity register, die code and clock detector readback
// Assumes: byte register port fed by the serial control engine
// Notes: detector fields are read only; host writes never disturb them
//
// Overview of operation
// R1: bit 5 inverts selected aux pin b
// R2: bit 4 inverts selected mute output
// R3: bit 3 inverts selected aux pin a
// R4: polarity register resets to zero
// R5: read-only 8-bit die code register
// R6: 3-bit detected sampling rate class
// R7: 4-bit detected master clock ratio
// R8: ratio codes 0000 error, then 32..2048
// R9: flag error on unsupported rate/ratio combination
// R10: source gives enough mclk ratio without pll
// R11: source keeps master clock below 50 MHz
// R12: 9-bit bit-clock ratio split over two registers
// R13: ratio equals bit clocks per frame
// R14: one bit clock per frame may be unreliable
// R15: detector fields read zero after reset
// R16: polarity applies after source selection
// R17: host writes leave measured fields untouched
// R18: reserved bits store and return written values
`include "clock_detect_defines.vh"

module clock_detect_gpio_polarity #(
    parameter [7:0] DIE_CODE = 8'h5A, // arbitrary value
    parameter [3:0] MIN_RATIO_CODE_NO_PLL = 4'h6,
    parameter PERIOD_W = 16
) (
    // system
    input wire clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_r,
    // audio clocks, sampled on clk
    input wire mclk_in,
    input wire bclk_in,
    input wire lrclk_in,
    input wire pll_enable,
    // selected pin sources from the output multiplexers
    input wire aux_a_selected,
    input wire mute_selected,
    input wire aux_b_selected,
    // pins
    output reg aux_pin_a_r,
    output reg mute_pin_r,
    output reg aux_pin_b_r,
    output reg clock_error_r
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [7:0] polarity_r;
    reg rate_rsv_r;
    reg [6:0] bitclk_hi_rsv_r;
    reg [2:0] detected_rate_class_r;
    reg [3:0] detected_master_ratio_r;
    reg [8:0] detected_bitclk_ratio_r;
    reg [2:0] rate_nxt;
    reg [3:0] ratio_nxt;
    reg combo_bad;
    reg [7:0] rdata_nxt;
    integer i;

    wire [PERIOD_W-1:0] period;
    wire [11:0] mclk_cnt;
    wire [8:0] bclk_cnt;
    wire meas_done;
    wire meas_timeout;

    // ----------------------------------------------------------------
    // measurement
    // ----------------------------------------------------------------
    clk_ratio_meter #(
        .PERIOD_W(PERIOD_W),
        .MCLK_W(12),
        .BCLK_W(9)
    ) meter (
        .clk(clk),
        .rst(rst),
        .mclk_in(mclk_in),
        .bclk_in(bclk_in),
        .lrclk_in(lrclk_in),
        .period_r(period),
        .mclk_cnt_r(mclk_cnt),
        .bclk_cnt_r(bclk_cnt),
        .done_r(meas_done),
        .timeout_r(meas_timeout)
    );

    // nominal master clock multiple for each ratio code
    function [11:0] ratio_of;
        input [3:0] code;
        begin
            case (code)
                4'h1: ratio_of = 12'd32;
                4'h2: ratio_of = 12'd48;
                4'h3: ratio_of = 12'd64;
                4'h4: ratio_of = 12'd128;
                4'h5: ratio_of = 12'd192;
                4'h6: ratio_of = 12'd256;
                4'h7: ratio_of = 12'd384;
                4'h8: ratio_of = 12'd512;
                4'h9: ratio_of = 12'd768;
                4'hA: ratio_of = 12'd1024;
                4'hB: ratio_of = 12'd1152;
                4'hC: ratio_of = 12'd1536;
                4'hD: ratio_of = 12'd2048;
                default: ratio_of = 12'd0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // classification
    // ----------------------------------------------------------------
    always @*
    begin
        rate_nxt = `RATE_ERR;
        if (meas_timeout)
            rate_nxt = `RATE_ERR;
        else if (period >= `WIN_384K_MIN && period <= `WIN_384K_MAX)
            rate_nxt = `RATE_384K; // R6
        else if (period >= `WIN_192K_MIN && period <= `WIN_192K_MAX)
            rate_nxt = `RATE_176_192K;
        else if (period >= `WIN_96K_MIN && period <= `WIN_96K_MAX)
            rate_nxt = `RATE_88_96K;
        else if (period >= `WIN_48K_MIN && period <= `WIN_48K_MAX)
            rate_nxt = `RATE_32_48K;
        else if (period >= `WIN_16K_MIN && period <= `WIN_16K_MAX)
            rate_nxt = `RATE_16K;
        else if (period >= `WIN_8K_MIN && period <= `WIN_8K_MAX)
            rate_nxt = `RATE_8K;
    end

    // sampled mclk edges jitter by one, so each code accepts +/-1
    always @*
    begin
        ratio_nxt = `RATIO_ERR; // R8
        for (i = 1; i <= 13; i = i + 1)
        begin
            if (!meas_timeout &&
                mclk_cnt + 12'd1 >= ratio_of(i[3:0]) &&
                mclk_cnt <= ratio_of(i[3:0]) + 12'd1)
                ratio_nxt = i[3:0]; // R7 R8
        end
    end

    // legal ratio may still pair badly with the rate
    always @*
    begin
        combo_bad = 1'b0;
        if ({4'h0, mclk_cnt} * `MCLK_LIMIT_FACTOR >= {16'h0000, period})
            combo_bad = 1'b1; // R9 R11
        if (!pll_enable && ratio_nxt < MIN_RATIO_CODE_NO_PLL)
            combo_bad = 1'b1; // R9 R10
    end

    // ----------------------------------------------------------------
    // detector result registers
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            detected_rate_class_r <= 3'h0; // R15
            detected_master_ratio_r <= 4'h0;
            detected_bitclk_ratio_r <= 9'h000;
            clock_error_r <= 1'b0;
        end
        else if (meas_done)
        begin
            // only the meter updates these; host writes never reach them
            detected_rate_class_r <= rate_nxt; // R17
            detected_master_ratio_r <= ratio_nxt;
            // a one-clock-per-frame bit clock gives whatever it counts
            detected_bitclk_ratio_r <= bclk_cnt; // R13 R14
            clock_error_r <= (rate_nxt == `RATE_ERR) |
                (ratio_nxt == `RATIO_ERR) | combo_bad; // R9
        end
    end

    // ----------------------------------------------------------------
    // host writes
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            polarity_r <= `POL_RESET; // R4
            rate_rsv_r <= 1'b0;
            bitclk_hi_rsv_r <= 7'h00;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `OFS_PIN_OUTPUT_POLARITY:
                    polarity_r <= reg_wdata; // R18
                `OFS_DETECTED_RATE_RATIO:
                    rate_rsv_r <= reg_wdata[7]; // R18 R17
                `OFS_BITCLK_RATIO_HIGH:
                    bitclk_hi_rsv_r <= reg_wdata[7:1]; // R18 R17
                default:
                    polarity_r <= polarity_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // host reads
    // ----------------------------------------------------------------
    always @*
    begin
        case (reg_addr)
            `OFS_PIN_OUTPUT_POLARITY:
                rdata_nxt = polarity_r;
            `OFS_DIE_IDENTIFIER:
                rdata_nxt = DIE_CODE; // R5
            `OFS_DETECTED_RATE_RATIO:
                rdata_nxt = {rate_rsv_r, detected_rate_class_r,
                    detected_master_ratio_r}; // R6 R7
            `OFS_BITCLK_RATIO_HIGH:
                rdata_nxt = {bitclk_hi_rsv_r,
                    detected_bitclk_ratio_r[8]}; // R12
            `OFS_BITCLK_RATIO_LOW:
                rdata_nxt = detected_bitclk_ratio_r[7:0]; // R12
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata_r <= 8'h00;
        else if (reg_rd)
            reg_rdata_r <= rdata_nxt;
    end

    // ----------------------------------------------------------------
    // pin polarity
    // ----------------------------------------------------------------
    wire [2:0] pin_src = {aux_b_selected, mute_selected, aux_a_selected};
    wire [2:0] pin_inv = {polarity_r[`POL_AUX_B_INVERT_BIT],
        polarity_r[`POL_MUTE_INVERT_BIT],
        polarity_r[`POL_AUX_A_INVERT_BIT]};
    wire [2:0] pin_nxt;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : pin_stage
            // inversion sits after the source mux, for any source
            assign pin_nxt[g] = pin_src[g] ^ pin_inv[g]; // R1 R2 R3 R16
        end
    endgenerate

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aux_pin_a_r <= 1'b0;
            mute_pin_r <= 1'b0;
            aux_pin_b_r <= 1'b0;
        end
        else
        begin
            aux_pin_a_r <= pin_nxt[0]; // R3
            mute_pin_r <= pin_nxt[1]; // R2
            aux_pin_b_r <= pin_nxt[2]; // R1
        end
    end

endmodule

// ==== clock_detect_gpio_polarity_tb.sv ====
// Purpose: self-checking bench for the polarity bank and clock detector
// Assumes: 250 MHz clock, audio clocks from the source model
// Notes: 8k and 16k frames are left out to keep the run short
`include "clock_detect_defines.vh"
module clock_detect_gpio_polarity_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] DIE = 8'hC3; // arbitrary value
    localparam int LIMIT = 95000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pll_enable = 1'b1;
    logic aux_a_selected = 1'b0;
    logic mute_selected = 1'b0;
    logic aux_b_selected = 1'b0;
    logic [15:0] period = 16'h1458;
    logic [11:0] mclk_ratio = 12'h100;
    logic [8:0] bclk_ratio = 9'h040;
    wire [7:0] reg_rdata_r;
    wire mclk;
    wire bclk;
    wire lrclk;
    wire aux_pin_a_r;
    wire mute_pin_r;
    wire aux_pin_b_r;
    wire clock_error_r;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    clock_detect_gpio_polarity #(
        .DIE_CODE(DIE)
    ) clock_detect_gpio_polarity_inst (
        .clk(clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r),
        .mclk_in(mclk),
        .bclk_in(bclk),
        .lrclk_in(lrclk),
        .pll_enable(pll_enable),
        .aux_a_selected(aux_a_selected),
        .mute_selected(mute_selected),
        .aux_b_selected(aux_b_selected),
        .aux_pin_a_r(aux_pin_a_r),
        .mute_pin_r(mute_pin_r),
        .aux_pin_b_r(aux_pin_b_r),
        .clock_error_r(clock_error_r)
    );
    audio_clock_source audio_clock_source_inst (
        .clk(clk),
        .rst(rst),
        .period(period),
        .mclk_ratio(mclk_ratio),
        .bclk_ratio(bclk_ratio),
        .mclk(mclk),
        .bclk(bclk),
        .lrclk(lrclk)
    );
    task automatic finish_test;
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            finish_test();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata_r;
    endtask
    task automatic test_reset;
        logic [7:0] d;
        reg_read(`OFS_PIN_OUTPUT_POLARITY, d);
        check(d, 8'h00);
        reg_write(`OFS_DIE_IDENTIFIER, 8'hFF);
        reg_read(`OFS_DIE_IDENTIFIER, d);
        check(d, DIE);
        reg_read(`OFS_DETECTED_RATE_RATIO, d);
        check(d, 8'h00);
        reg_read(`OFS_BITCLK_RATIO_HIGH, d);
        check(d, 8'h00);
        reg_read(8'h59, d);
        check(d, 8'h00);
    endtask
    task automatic test_polarity;
        logic [7:0] vals [6] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h38, 8'hC7};
        logic [7:0] d;
        logic [2:0] s;
        foreach (vals[i])
        begin
            reg_write(`OFS_PIN_OUTPUT_POLARITY, vals[i]);
            reg_read(`OFS_PIN_OUTPUT_POLARITY, d);
            check(d, vals[i]);
            for (int k = 0; k < 8; k++)
            begin
                s = k[2:0];
                {aux_b_selected, mute_selected, aux_a_selected} = s;
                @(negedge clk);
                @(negedge clk);
                d = {5'h00, aux_pin_b_r, mute_pin_r, aux_pin_a_r};
                check(d, {5'h00, s ^ vals[i][5:3]});
            end
        end
    endtask
    // waits out the frame in flight plus three clean frames
    // err is the expected clock error level, worked out from the rules
    task automatic detect_case(input logic [15:0] p, input logic [11:0] m,
        input logic [8:0] b, input logic [7:0] exp, input logic err);
        logic [7:0] d;
        int n;
        n = 3 * int'(p) + int'(period) + 8;
        period = p;
        mclk_ratio = m;
        bclk_ratio = b;
        repeat (n) @(negedge clk);
        reg_read(`OFS_DETECTED_RATE_RATIO, d);
        check(d, exp);
        reg_read(`OFS_BITCLK_RATIO_HIGH, d);
        check(d, {7'h00, b[8]});
        reg_read(`OFS_BITCLK_RATIO_LOW, d);
        check(d, b[7:0]);
        check({7'h00, clock_error_r}, {7'h00, err});
    endtask
    task automatic test_detect;
        detect_case(16'h028B, 12'h040, 9'h040, 8'h63, 1'b0);
        // 100 clocks per frame matches no ratio code
        detect_case(16'h028B, 12'h064, 9'h040, 8'h60, 1'b1);
        // 400-cycle frame is shorter than the shortest rate window
        detect_case(16'h0190, 12'h040, 9'h040, 8'h03, 1'b1);
        detect_case(16'h0516, 12'h080, 9'h040, 8'h54, 1'b0);
        detect_case(16'h0A2C, 12'h0C0, 9'h040, 8'h45, 1'b0);
        detect_case(16'h1458, 12'h100, 9'h040, 8'h36, 1'b0);
        detect_case(16'h1458, 12'h200, 9'h12C, 8'h38, 1'b0);
    endtask
    task automatic test_write_guard;
        logic [7:0] d;
        reg_write(`OFS_DETECTED_RATE_RATIO, 8'hFF);
        reg_write(`OFS_BITCLK_RATIO_HIGH, 8'hFF);
        reg_write(`OFS_BITCLK_RATIO_LOW, 8'h00);
        reg_read(`OFS_DETECTED_RATE_RATIO, d);
        check(d, 8'hB8);
        reg_read(`OFS_BITCLK_RATIO_HIGH, d);
        check(d, 8'hFF);
        reg_read(`OFS_BITCLK_RATIO_LOW, d);
        check(d, 8'h2C);
        reg_write(`OFS_DETECTED_RATE_RATIO, 8'h00);
        reg_write(`OFS_BITCLK_RATIO_HIGH, 8'h00);
    endtask
    // legal ratio code 3 but too few cycles per sample without the pll
    task automatic test_no_pll;
        pll_enable = 1'b0;
        detect_case(16'h028B, 12'h040, 9'h040, 8'h63, 1'b1);
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        test_reset();
        test_polarity();
        test_detect();
        test_write_guard();
        test_no_pll();
        finish_test();
    end
endmodule

// ==== clock_detect_monitor.sv ====
// Purpose: assertions on the polarity bank and detector ports
// Assumes: one clock domain, async active high reset
// Notes: polarity and the rate register reserved bit are shadowed from host writes
`include "clock_detect_defines.vh"
module clock_detect_monitor #(
    parameter [7:0] DIE_CODE = 8'h5A
) (
    // system
    input wire clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_r,
    // clocks and pins
    input wire lrclk_in,
    input wire aux_a_selected,
    input wire mute_selected,
    input wire aux_b_selected,
    input wire aux_pin_a_r,
    input wire mute_pin_r,
    input wire aux_pin_b_r,
    input wire clock_error_r
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] pol_r;
    reg rsv_r;
    reg live_r;
    reg lr_d_r;
    reg [2:0] since_rise_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // shadows: the pins lag one cycle, so the first edge is skipped
    // ----
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pol_r <= 8'h00;
            rsv_r <= 1'b0;
            live_r <= 1'b0;
            lr_d_r <= 1'b0;
            since_rise_r <= 3'h7;
        end
        else
        begin
            live_r <= 1'b1;
            lr_d_r <= lrclk_in;
            if (reg_wr && reg_addr == `OFS_PIN_OUTPUT_POLARITY)
                pol_r <= reg_wdata;
            if (reg_wr && reg_addr == `OFS_DETECTED_RATE_RATIO)
                rsv_r <= reg_wdata[7];
            if (lrclk_in && !lr_d_r)
                since_rise_r <= 3'h0;
            else if (since_rise_r != 3'h7)
                since_rise_r <= since_rise_r + 3'h1;
        end
    end
    pin_a_polarity_a: assert property (live_r |->
        aux_pin_a_r == ($past(aux_a_selected) ^ $past(pol_r[3])))
        else $error("aux pin a level wrong");
    mute_polarity_a: assert property (live_r |->
        mute_pin_r == ($past(mute_selected) ^ $past(pol_r[4])))
        else $error("mute pin level wrong");
    pin_b_polarity_a: assert property (live_r |->
        aux_pin_b_r == ($past(aux_b_selected) ^ $past(pol_r[5])))
        else $error("aux pin b level wrong");
    die_code_a: assert property (reg_rd &&
        reg_addr == `OFS_DIE_IDENTIFIER |=> reg_rdata_r == DIE_CODE)
        else $error("die code wrong");
    pol_read_a: assert property (reg_rd && !reg_wr &&
        reg_addr == `OFS_PIN_OUTPUT_POLARITY |=> reg_rdata_r == $past(pol_r))
        else $error("polarity readback wrong");
    rate_code_a: assert property (reg_rd &&
        reg_addr == `OFS_DETECTED_RATE_RATIO |=> reg_rdata_r[6:4] != 3'h7)
        else $error("rate class code out of range");
    ratio_code_a: assert property (reg_rd &&
        reg_addr == `OFS_DETECTED_RATE_RATIO |=> reg_rdata_r[3:0] <= 4'hD)
        else $error("ratio code out of range");
    rsv_keep_a: assert property (reg_rd && !reg_wr &&
        reg_addr == `OFS_DETECTED_RATE_RATIO |=> reg_rdata_r[7] == $past(rsv_r))
        else $error("reserved bit lost");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_r))
        else $error("read data moved without a read");
    err_timing_a: assert property ($changed(clock_error_r) |->
        since_rise_r <= 3'h4) else $error("clock error moved off frame end");
endmodule
bind clock_detect_gpio_polarity clock_detect_monitor #(
    .DIE_CODE(DIE_CODE)
) clock_detect_monitor_inst (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r),
    .lrclk_in(lrclk_in),
    .aux_a_selected(aux_a_selected),
    .mute_selected(mute_selected),
    .aux_b_selected(aux_b_selected),
    .aux_pin_a_r(aux_pin_a_r),
    .mute_pin_r(mute_pin_r),
    .aux_pin_b_r(aux_pin_b_r),
    .clock_error_r(clock_error_r)
);
